// File: core/qrcb_config_bank.v
// quad redriver configuration bank with strap and serial register control
`include "qrcb_defines.vh"
module qrcb_config_bank
#(
    parameter NCH = 4
)
(
    input  wire                 clk_sys_i,
    input  wire                 reset_n_i,
    input  wire                 serial_mode_i,
    input  wire                 detect_speed_pin_i,
    input  wire                 squelch_strap_i,
    input  wire                 offset_cancel_pin_i,
    input  wire                 outputs_on_strap_i,
    input  wire                 emphasis_strap_lo_i,
    input  wire                 emphasis_strap_hi_i,
    input  wire                 drive_strap_lo_i,
    input  wire                 drive_strap_hi_i,
    input  wire                 wr_en_i,
    input  wire                 rd_en_i,
    input  wire [2:0]           addr_i,
    input  wire [7:0]           wdata_i,
    output reg  [7:0]           rdata_o,
    input  wire [NCH-1:0]       detect_raw_n_i,
    input  wire [NCH-1:0]       data_i,
    output reg  [2*NCH-1:0]     emphasis_code_o,
    output reg  [2*NCH-1:0]     drive_code_o,
    output reg  [NCH-1:0]       power_on_o,
    output reg  [NCH-1:0]       squelch_o,
    output reg  [NCH-1:0]       speed_fast_o,
    output reg  [NCH-1:0]       threshold_high_o,
    output reg  [NCH-1:0]       offset_cancel_o,
    output reg  [NCH-1:0]       data_p_o,
    output reg  [NCH-1:0]       data_n_o,
    output reg  [NCH-1:0]       common_mode_o
);

    reg  [7:0]      preemphasis_select;
    reg  [7:0]      drive_level_select;
    reg  [7:0]      output_on_polarity;
    reg  [7:0]      detect_mode;
    reg  [7:0]      offset_cancel_threshold;
    reg  [3:0]      detect_status;
    wire [1:0]      emph_strap;
    wire [1:0]      drive_strap;
    reg  [7:0]      next_rdata;
    reg  [NCH-1:0]  eff_on;
    reg  [NCH-1:0]  eff_sq;
    reg  [NCH-1:0]  eff_inv;
    integer         i;
    integer         j;
    integer         k;

    // replicate one bit into every channel nibble slot
    function [3:0] qrcb_rep4;
        input b;
        begin
            qrcb_rep4 = {4{b}};
        end
    endfunction

    // in pin mode only channel 0 reads valid, the rest read zero
    function [7:0] qrcb_pin_view2;
        input [1:0] code;
        begin
            qrcb_pin_view2 = {6'h00, code};
        end
    endfunction

    function [7:0] qrcb_pin_view1;
        input hi;
        input lo;
        begin
            qrcb_pin_view1 = {3'h0, hi, 3'h0, lo};
        end
    endfunction

    // leg value after the optional polarity inversion
    function qrcb_flip;
        input d;
        input inv;
        begin
            qrcb_flip = d ^ inv;
        end
    endfunction

    assign emph_strap  = {emphasis_strap_hi_i,
                          emphasis_strap_lo_i};
    assign drive_strap = {drive_strap_hi_i, drive_strap_lo_i};

    // reset is synchronous, so loading strap levels here is legal
    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            preemphasis_select      <= {4{emph_strap}};
            drive_level_select      <= {4{drive_strap}};
            output_on_polarity      <= {qrcb_rep4(outputs_on_strap_i),
                                        `QRCB_POL_RESET};
            detect_mode             <=
                {qrcb_rep4(squelch_strap_i),
                 qrcb_rep4(detect_speed_pin_i)};
            offset_cancel_threshold <=
                {qrcb_rep4(offset_cancel_pin_i),
                 `QRCB_THR_RESET};
        end
        else if (wr_en_i && serial_mode_i)
        begin
            // writes in pin mode and to status are accepted and dropped
            case (addr_i)
                `QRCB_ADDR_EMPHASIS: preemphasis_select      <= wdata_i;
                `QRCB_ADDR_DRIVE:    drive_level_select      <= wdata_i;
                `QRCB_ADDR_ONPOL:    output_on_polarity      <= wdata_i;
                `QRCB_ADDR_DETMODE:  detect_mode             <= wdata_i;
                `QRCB_ADDR_OCTHR:    offset_cancel_threshold <= wdata_i;
                default:
                    preemphasis_select <= preemphasis_select;
            endcase
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            detect_status <= `QRCB_ZERO_NIBBLE;
        else
            detect_status <= detect_raw_n_i[3:0];
    end

    always @*
    begin
        next_rdata = `QRCB_ZERO_BYTE;
        if (serial_mode_i)
        begin
            // serial mode: the host sees the registers it wrote
            case (addr_i)
                `QRCB_ADDR_EMPHASIS:
                    next_rdata = preemphasis_select;
                `QRCB_ADDR_DRIVE:
                    next_rdata = drive_level_select;
                `QRCB_ADDR_ONPOL:
                    next_rdata = output_on_polarity;
                `QRCB_ADDR_DETMODE:
                    next_rdata = detect_mode;
                `QRCB_ADDR_OCTHR:
                    next_rdata = offset_cancel_threshold;
                `QRCB_ADDR_STATUS:
                    next_rdata = {`QRCB_ZERO_NIBBLE,
                                  detect_status};
                default:
                    next_rdata = `QRCB_ZERO_BYTE;
            endcase
        end
        else
        begin
            // pin mode: only channel 0 bits are valid, the rest read zero; status reads all four channels
            case (addr_i)
                `QRCB_ADDR_EMPHASIS:
                    next_rdata = qrcb_pin_view2(emph_strap);
                `QRCB_ADDR_DRIVE:
                    next_rdata = qrcb_pin_view2(drive_strap);
                `QRCB_ADDR_ONPOL:
                    next_rdata = qrcb_pin_view1(outputs_on_strap_i, 1'b0);
                `QRCB_ADDR_DETMODE:
                    next_rdata = qrcb_pin_view1(squelch_strap_i,
                                                detect_speed_pin_i);
                `QRCB_ADDR_OCTHR:
                    next_rdata = qrcb_pin_view1(offset_cancel_pin_i, 1'b1);
                `QRCB_ADDR_STATUS:
                    next_rdata = {`QRCB_ZERO_NIBBLE,
                                  detect_status};
                default:
                    next_rdata = `QRCB_ZERO_BYTE;
            endcase
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            rdata_o <= `QRCB_ZERO_BYTE;
        else if (rd_en_i)
            rdata_o <= next_rdata;
    end

    // effective per-channel controls: straps drive all channels in pin mode
    always @*
    begin
        eff_on  = {NCH{1'b0}};
        eff_sq  = {NCH{1'b0}};
        eff_inv = {NCH{1'b0}};
        for (j = 0; j < NCH; j = j + 1)
        begin
            if (serial_mode_i)
            begin
                eff_on[j]  = output_on_polarity[`QRCB_HI_BASE+j];
                eff_sq[j]  = detect_mode[`QRCB_HI_BASE+j];
                eff_inv[j] = output_on_polarity[j];
            end
            else
            begin
                eff_on[j]  = outputs_on_strap_i;
                eff_sq[j]  = squelch_strap_i;
                eff_inv[j] = 1'b0;
            end
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            emphasis_code_o  <= {2*NCH{1'b0}};
            drive_code_o     <= {2*NCH{1'b0}};
            speed_fast_o     <= {NCH{1'b0}};
            threshold_high_o <= {NCH{1'b1}};
            offset_cancel_o  <= {NCH{1'b0}};
        end
        else
        begin
            for (i = 0; i < NCH; i = i + 1)
            begin
                if (serial_mode_i)
                begin
                    emphasis_code_o[2*i +: 2] <=
                        preemphasis_select[2*i +: 2];
                    drive_code_o[2*i +: 2] <=
                        drive_level_select[2*i +: 2];
                    speed_fast_o[i] <= detect_mode[i];
                    offset_cancel_o[i] <=
                        offset_cancel_threshold[`QRCB_HI_BASE+i];
                end
                else
                begin
                    emphasis_code_o[2*i +: 2] <= emph_strap;
                    drive_code_o[2*i +: 2] <= drive_strap;
                    speed_fast_o[i] <= detect_speed_pin_i;
                    offset_cancel_o[i] <= offset_cancel_pin_i;
                end
                // threshold is a serial-only setting, even in pin mode
                threshold_high_o[i] <=
                    offset_cancel_threshold[i];
            end
        end
    end

    // output stage: power-down wins over squelch, squelch over data
    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            power_on_o    <= {NCH{1'b0}};
            squelch_o     <= {NCH{1'b0}};
            data_p_o      <= {NCH{1'b0}};
            data_n_o      <= {NCH{1'b0}};
            common_mode_o <= {NCH{1'b1}};
        end
        else
        begin
            for (k = 0; k < NCH; k = k + 1)
            begin
                power_on_o[k] <= eff_on[k];
                // a lost signal squelches only a powered channel
                squelch_o[k]  <= eff_on[k] & eff_sq[k] & detect_raw_n_i[k];
                if (!eff_on[k])
                begin
                    // powered off: no leg driven, not held at common mode
                    data_p_o[k]      <= 1'b0;
                    data_n_o[k]      <= 1'b0;
                    common_mode_o[k] <= 1'b0;
                end
                else if (eff_sq[k] && detect_raw_n_i[k])
                begin
                    data_p_o[k]      <= 1'b0;
                    data_n_o[k]      <= 1'b0;
                    common_mode_o[k] <= 1'b1;
                end
                else
                begin
                    data_p_o[k]      <= qrcb_flip(data_i[k], eff_inv[k]);
                    data_n_o[k]      <= ~qrcb_flip(data_i[k], eff_inv[k]);
                    common_mode_o[k] <= 1'b0;
                end
            end
        end
    end

endmodule // qrcb_config_bank

// File: core/qrcb_defines.vh
// constants and register map of the quad redriver configuration bank
// Behaviour
// - speed strap low slow, high fast detect
// - squelch strap low disables squelch, detect status still read
// - squelched output held at zero differential
// - every channel detect status readable by host
// - per channel threshold, serial only, default high
// - offset cancel enable by strap or register
// - emphasis code two bits, high strap msb
// - emphasis global by straps or per channel
// - drive code 00,01,10 selects levels 1-3
// - six 8-bit registers, 1-5 rw, 6 ro
// - emphasis field per channel, reset from straps
// - drive field per channel, reset from straps
// - output on bits 7:4, invert bits 3:0
// - output on bit zero powers channel off
// - invert bit one inverts channel polarity
// - straps give global settings for all channels
// - pin mode: straps control all four channels
// - detect mode: squelch 7:4, speed 3:0
// - offset cancel 7:4, threshold 3:0 reset one
// - status bits 3:0, zero means signal present
`ifndef QRCB_DEFINES_VH
`define QRCB_DEFINES_VH
`define QRCB_ADDR_W           3
`define QRCB_ADDR_EMPHASIS    3'h1
`define QRCB_ADDR_DRIVE       3'h2
`define QRCB_ADDR_ONPOL       3'h3
`define QRCB_ADDR_DETMODE     3'h4
`define QRCB_ADDR_OCTHR       3'h5
`define QRCB_ADDR_STATUS      3'h6
`define QRCB_HI_NIBBLE        7:4
`define QRCB_LO_NIBBLE        3:0
`define QRCB_THR_RESET        4'hf
`define QRCB_POL_RESET        4'h0
`define QRCB_ZERO_NIBBLE      4'h0
`define QRCB_ZERO_BYTE        8'h00
`define QRCB_DRIVE_BAD        2'h3
`define QRCB_HI_BASE          4
`endif

// File: sim/qrcb_config_bank_monitor.sv
// concurrent checks on the configuration bank ports
module qrcb_monitor
#(
    parameter NCH = 4
)
(
    input wire logic             clk_sys_i,
    input wire logic             reset_n_i,
    input wire logic             serial_mode_i,
    input wire logic             wr_en_i,
    input wire logic             rd_en_i,
    input wire logic [2:0]       addr_i,
    input wire logic [7:0]       wdata_i,
    input wire logic [7:0]       rdata_o,
    input wire logic [NCH-1:0]   detect_raw_n_i,
    input wire logic             outputs_on_strap_i,
    input wire logic             detect_speed_pin_i,
    input wire logic [2*NCH-1:0] emphasis_code_o,
    input wire logic [2*NCH-1:0] drive_code_o,
    input wire logic [NCH-1:0]   power_on_o,
    input wire logic [NCH-1:0]   speed_fast_o,
    input wire logic [NCH-1:0]   threshold_high_o,
    input wire logic [NCH-1:0]   data_p_o,
    input wire logic [NCH-1:0]   data_n_o,
    input wire logic [NCH-1:0]   common_mode_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_emphasis_write_applied: assert property (
        serial_mode_i && wr_en_i && addr_i == 3'h1
        ##1 serial_mode_i ##1 serial_mode_i
        |-> emphasis_code_o == $past(wdata_i, 2))
        else $error("emphasis write not applied");
    a_drive_write_applied: assert property (
        serial_mode_i && wr_en_i && addr_i == 3'h2
        ##1 serial_mode_i ##1 serial_mode_i
        |-> drive_code_o == $past(wdata_i, 2))
        else $error("drive write not applied");
    a_status_upper_zero: assert property (
        rd_en_i && addr_i == 3'h6 |=> rdata_o[7:4] == 4'h0)
        else $error("status upper bits set");
    a_status_bits_read: assert property (
        rd_en_i && addr_i == 3'h6 && $past(reset_n_i)
        |=> rdata_o[3:0] == $past(detect_raw_n_i, 2))
        else $error("status bits wrong");
    a_squelch_zero_diff: assert property (
        ((data_p_o | data_n_o) & common_mode_o) == 0)
        else $error("squelched leg driven");
    a_pin_power_follows: assert property (
        !serial_mode_i && $past(!serial_mode_i) && $past(reset_n_i)
        && $stable(outputs_on_strap_i)
        |-> power_on_o == {NCH{outputs_on_strap_i}})
        else $error("pin power wrong");
    a_pin_speed_follows: assert property (
        !serial_mode_i && $past(!serial_mode_i) && $past(reset_n_i)
        && $stable(detect_speed_pin_i)
        |-> speed_fast_o == {NCH{detect_speed_pin_i}})
        else $error("pin speed wrong");
    a_threshold_reset_high: assert property (
        $rose(reset_n_i) |-> threshold_high_o == {NCH{1'b1}})
        else $error("threshold not high");
    a_rdata_holds: assert property (
        !rd_en_i |=> $stable(rdata_o))
        else $error("read data moved");
endmodule // qrcb_monitor
bind qrcb_config_bank qrcb_monitor #(.NCH(NCH)) qrcb_monitor_inst (.*);

// File: sim/qrcb_config_bank_tb.sv
// self-checking bench of the configuration bank
module qrcb_config_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys_i = 0, reset_n_i = 0, serial_mode_i = 1;
    logic       wr_en_i = 0, rd_en_i = 0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00, set = 8'h00, pins, v, rdata_o;
    logic [7:0] emphasis_code_o, drive_code_o;
    logic [3:0] detect_raw_n_i = 4'h0, data_i = 4'h0, power_on_o, squelch_o;
    logic [3:0] speed_fast_o, threshold_high_o, offset_cancel_o;
    logic [3:0] data_p_o, data_n_o, common_mode_o;
    int         miscompares = 0, tests_run = 0;
    initial forever #2 clk_sys_i = ~clk_sys_i;
    qrcb_strap_model qrcb_strap_model_inst (.clk_i(clk_sys_i), .set_i(set),
        .pins_o(pins));
    qrcb_config_bank qrcb_config_bank_inst (.clk_sys_i, .reset_n_i,
        .serial_mode_i,
        .detect_speed_pin_i(pins[7]), .squelch_strap_i(pins[6]),
        .offset_cancel_pin_i(pins[5]), .outputs_on_strap_i(pins[4]),
        .emphasis_strap_lo_i(pins[3]), .emphasis_strap_hi_i(pins[2]),
        .drive_strap_lo_i(pins[1]), .drive_strap_hi_i(pins[0]), .wr_en_i,
        .rd_en_i, .addr_i, .wdata_i, .rdata_o, .detect_raw_n_i, .data_i,
        .emphasis_code_o, .drive_code_o, .power_on_o, .squelch_o,
        .speed_fast_o, .threshold_high_o, .offset_cancel_o, .data_p_o,
        .data_n_o, .common_mode_o);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) #1 {wr_en_i, addr_i, wdata_i} = {1'b1, a, d};
        @(posedge clk_sys_i) #1 wr_en_i = 0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys_i) #1 {rd_en_i, addr_i} = {1'b1, a};
        @(posedge clk_sys_i) #1 rd_en_i = 0;
        d = rdata_o;
    endtask
    task automatic rst(input logic [7:0] s, input logic m);
        {set, serial_mode_i} = {s, m};
        @(posedge clk_sys_i) #1 reset_n_i = 0;
        repeat (2) @(posedge clk_sys_i);
        #1 reset_n_i = 1;
    endtask
    task automatic t_defaults();
        rst(8'hb9, 1);
        rd(1, v);
        chk(v, 8'h55);
        rd(2, v);
        chk(v, 8'haa);
        rd(3, v);
        chk(v, 8'hf0);
        rd(4, v);
        chk(v, 8'h0f);
        rd(5, v);
        chk(v, 8'hff);
        chk({4'h0, threshold_high_o}, 8'h0f);
        $display("test done: reset defaults");
    endtask
    task automatic t_write();
        detect_raw_n_i = 4'h5;
        wr(1, 8'he4);
        wr(2, 8'h21);
        wr(3, 8'h5e);
        wr(6, 8'hff);
        wr(7, 8'h3c);
        rd(1, v);
        chk(v, 8'he4);
        rd(2, v);
        chk(v, 8'h21);
        rd(3, v);
        chk(v, 8'h5e);
        rd(6, v);
        chk(v, 8'h05);
        rd(7, v);
        chk(v, 8'h00);
        chk(emphasis_code_o, 8'he4);
        chk(drive_code_o, 8'h21);
        chk({4'h0, power_on_o}, 8'h05);
        $display("test done: write and read back");
    endtask
    task automatic t_squelch();
        // squelch kept off where offset cancel is on
        detect_raw_n_i = 4'h3;
        wr(4, 8'h50);
        wr(5, 8'ha0);
        repeat (2) @(posedge clk_sys_i);
        #1 chk({4'h0, squelch_o}, 8'h01);
        chk({4'h0, speed_fast_o}, 8'h00);
        chk({offset_cancel_o, threshold_high_o}, 8'ha0);
        chk({data_p_o, data_n_o}, 8'h40);
        chk({4'h0, common_mode_o}, 8'h01);
        $display("test done: squelch and threshold");
    endtask
    task automatic t_pins();
        rst(8'he6, 0);
        wr(1, 8'h00);
        chk({speed_fast_o, offset_cancel_o}, 8'hff);
        chk({4'h0, power_on_o}, 8'h00);
        chk({4'h0, common_mode_o}, 8'h00);
        chk(emphasis_code_o, 8'haa);
        chk(drive_code_o, 8'h55);
        rd(1, v);
        chk(v, 8'h02);
        $display("test done: strap mode");
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        miscompares++;
        final_report();
    end
    initial
    begin
        t_defaults();
        t_write();
        t_squelch();
        t_pins();
        final_report();
    end
endmodule // qrcb_config_bank_tb

// File: sim/qrcb_strap_model.sv
// board straps as seen by the bank: strap levels and speed/squelch pins
module qrcb_strap_model
(
    input  wire logic       clk_i,
    input  wire logic [7:0] set_i,
    output logic      [7:0] pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins_o = 8'h00;
    // order: speed, squelch, offset, on, pe lo, pe hi, lv lo, lv hi
    // lv lo dropped when both lv straps asked: code 11 is never legal
    always @(posedge clk_i)
        pins_o <= #1 {set_i[7:2],
                      set_i[1] & ~set_i[0],
                      set_i[0]};
endmodule // qrcb_strap_model
